//--- src/sbb_pkg.sv
package sbb_pkg;
   // ------------------------------------------------------------
   // Geometry
   // ------------------------------------------------------------
   localparam int ROW_W = 14;
   localparam int ADDR_W = 14;
   localparam int COL_W = 10;
   localparam int BANK_W = 2;
   localparam int NUM_BANKS = 4;
   localparam int DATA_W = 16;
   localparam int LANES = 2;
   localparam int MEM_AW = 9;
   localparam int PRE_BIT = 10;
   localparam int ROW_LSB_BITS = 13;
   localparam int CL_MAX = 3;
   localparam int BL_MAX = 8;

   // ------------------------------------------------------------
   // Organisation select
   // ------------------------------------------------------------
   localparam logic [1:0] ORG_X16 = 2'h0;
   localparam logic [1:0] ORG_X32_STD = 2'h1;
   localparam logic [1:0] ORG_X32_RED = 2'h2;
   localparam logic [COL_W-1:0] COLS_X16 = 10'h3ff;
   localparam logic [COL_W-1:0] COLS_X32_STD = 10'h1ff;
   localparam logic [COL_W-1:0] COLS_X32_RED = 10'h0ff;

   // ------------------------------------------------------------
   // Burst length encodings
   // ------------------------------------------------------------
   localparam logic [1:0] BL_1 = 2'h0;
   localparam logic [1:0] BL_2 = 2'h1;
   localparam logic [1:0] BL_4 = 2'h2;
   localparam logic [1:0] BL_8 = 2'h3;

   // ------------------------------------------------------------
   // Commands as {ras_n, cas_n, we_n}
   // ------------------------------------------------------------
   typedef enum logic [2:0]
   {
      CMD_ACTIVATE = 3'h3,
      CMD_READ = 3'h5,
      CMD_WRITE = 3'h4,
      CMD_PRECHARGE = 3'h2,
      CMD_TERMINATE = 3'h6,
      CMD_NOP = 3'h7
   } sbb_cmd_t;

   typedef enum logic [1:0]
   {
      ST_IDLE = 2'h0,
      ST_READ = 2'h1,
      ST_WRITE = 2'h2
   } sbb_state_t;

   localparam logic [ROW_W-1:0] ROW_RESET = 14'h0000;
   localparam logic [COL_W-1:0] COL_RESET = 10'h000;
endpackage

//--- src/sbb_mem.sv
`timescale 1ns/1ps
module sbb_mem
(
   input wire logic clk,
   input wire logic wr_en,
   input wire logic [sbb_pkg::LANES-1:0] wr_lane,
   input wire logic [sbb_pkg::MEM_AW-1:0] addr,
   input wire logic [sbb_pkg::DATA_W-1:0] wr_data,
   output logic [sbb_pkg::DATA_W-1:0] rd_data
);
   import sbb_pkg::*;

   // Byte-lane write, registered read; each lane owns its own array
   genvar g;
   generate
      for (g = 0; g < LANES; g++)
      begin : lane
         logic [7:0] store [0:(1<<MEM_AW)-1];
         always_ff @(posedge clk)
         begin
            if (wr_en && wr_lane[g])
            begin
               store[addr] <= wr_data[g*8 +: 8];
            end
            rd_data[g*8 +: 8] <= store[addr];
         end
      end
   endgenerate
endmodule

//--- src/sbb_core.sv
`timescale 1ns/1ps
// Function
// [RL1] All inputs, commands, address and write data are sampled on rising clock only.
// [RL2] Four independent banks, each keeping its own open row.
// [RL3] x16 organisation: 8,192 rows of 1K columns, sixteen bits each.
// [RL4] x32 standard organisation: 8,192 rows of 512 columns.
// [RL5] x32 reduced page: 16,384 rows of 256 columns, extra row bit.
// [RL6] Controller activates a row before reading or writing that bank.
// [RL7] Activate: bank selects choose bank, address lines choose row.
// [RL8] Read or write address gives first burst column in open row.
// [RL9] Burst walks a programmed count in programmed order, columns generated inside.
// [RL10] Burst length 1, 2, 4 or 8; terminate cuts a read short.
// [RL11] Auto precharge closes the row by itself after the burst ends.
// [RL12] A new column address is accepted every clock cycle.
// [RL13] Controller should precharge one bank while using another.
// [RL14] Address bit ten with read or write requests auto precharge.
// [RL15] Address bit ten with precharge selects all banks or one bank.
// [RL16] Commands are ignored while chip select is sampled high.
// [RL17] Byte mask floats read byte two clocks later, blocks write byte.
// [RL18] First read word appears CAS latency clocks after the read command; the core drives it one clock later, at CAS latency plus one.
module sbb_core
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [1:0] org_select,
   input wire logic [1:0] burst_length,
   input wire logic interleave,
   input wire logic [1:0] cas_latency,
   input wire logic chip_select_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic bank_select_low,
   input wire logic bank_select_high,
   input wire logic [sbb_pkg::ADDR_W-1:0] row_column_address_lines,
   input wire logic lower_byte_lane_mask,
   input wire logic upper_byte_lane_mask,
   input wire logic [sbb_pkg::DATA_W-1:0] dq_in,
   output logic [sbb_pkg::DATA_W-1:0] dq_out,
   output logic [sbb_pkg::LANES-1:0] dq_oe_n,
   output logic [sbb_pkg::NUM_BANKS-1:0] bank_open,
   output logic [sbb_pkg::NUM_BANKS*sbb_pkg::ROW_W-1:0] open_rows
);
   import sbb_pkg::*;

   // ------------------------------------------------------------
   // Input capture
   // ------------------------------------------------------------
   logic cs_q;
   logic [2:0] cmd_q;
   logic [BANK_W-1:0] bank_q;
   logic [ADDR_W-1:0] addr_q;
   logic [LANES-1:0] mask_q;
   logic [DATA_W-1:0] din_q;

   always_ff @(posedge clk or posedge rst)  // see [RL1]
   begin
      if (rst)
      begin
         cs_q <= 1'b0;
         cmd_q <= CMD_NOP;
         bank_q <= '0;
         addr_q <= '0;
         mask_q <= '0;
         din_q <= '0;
      end
      else
      begin
         cs_q <= ~chip_select_n;
         cmd_q <= {ras_n, cas_n, we_n};
         bank_q <= {bank_select_high, bank_select_low};
         addr_q <= row_column_address_lines;
         mask_q <= {upper_byte_lane_mask, lower_byte_lane_mask};
         din_q <= dq_in;
      end
   end

   sbb_cmd_t cmd;
   assign cmd = cs_q ? sbb_cmd_t'(cmd_q) : CMD_NOP;  // see [RL16]

   logic is_act;
   logic is_rd;
   logic is_wr;
   logic is_pre;
   logic is_term;
   assign is_act = (cmd == CMD_ACTIVATE);
   assign is_rd = (cmd == CMD_READ) && bank_open[bank_q];  // see [RL6]
   assign is_wr = (cmd == CMD_WRITE) && bank_open[bank_q];
   assign is_pre = (cmd == CMD_PRECHARGE);
   assign is_term = (cmd == CMD_TERMINATE);

   // ------------------------------------------------------------
   // Organisation
   // ------------------------------------------------------------
   logic [COL_W-1:0] col_mask;
   logic [ROW_W-1:0] row_in;
   always_comb
   begin
      case (org_select)
         ORG_X32_STD: col_mask = COLS_X32_STD;  // see [RL4]
         ORG_X32_RED: col_mask = COLS_X32_RED;  // see [RL5]
         default: col_mask = COLS_X16;  // see [RL3]
      endcase
      if (org_select == ORG_X32_RED)
      begin
         row_in = addr_q;
      end
      else
      begin
         row_in = {1'b0, addr_q[ROW_LSB_BITS-1:0]};
      end
   end

   // ------------------------------------------------------------
   // Burst engine
   // ------------------------------------------------------------
   sbb_state_t state;
   logic [BANK_W-1:0] bst_bank;
   logic [COL_W-1:0] start_col;
   logic [2:0] beat;
   logic [2:0] last_beat;
   logic auto_pre;
   logic [2:0] bl_last;

   always_comb
   begin
      case (burst_length)  // see [RL10]
         BL_1: bl_last = 3'h0;
         BL_2: bl_last = 3'h1;
         BL_4: bl_last = 3'h3;
         default: bl_last = 3'h7;
      endcase
   end

   logic bst_active;
   logic bst_end;
   assign bst_active = (state != ST_IDLE);
   assign bst_end = bst_active && (beat == last_beat) && !is_rd && !is_wr;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state <= ST_IDLE;
         bst_bank <= '0;
         start_col <= COL_RESET;
         beat <= '0;
         last_beat <= '0;
         auto_pre <= 1'b0;
      end
      else if (is_rd || is_wr)  // see [RL12]
      begin
         state <= is_rd ? ST_READ : ST_WRITE;
         bst_bank <= bank_q;
         start_col <= addr_q[COL_W-1:0] & col_mask;  // see [RL8]
         beat <= '0;
         last_beat <= bl_last;
         auto_pre <= addr_q[PRE_BIT];  // see [RL14]
      end
      else if (bst_end || (is_term && state == ST_READ))  // see [RL10]
      begin
         state <= ST_IDLE;
         auto_pre <= 1'b0;
      end
      else if (bst_active)
      begin
         beat <= beat + 3'h1;
      end
   end

   // Column walk inside the burst-length block
   logic [COL_W-1:0] cur_col;
   logic [2:0] wrap_mask;
   logic [2:0] low_bits;
   always_comb  // see [RL9]
   begin
      wrap_mask = last_beat;
      if (interleave)
      begin
         low_bits = (start_col[2:0] ^ beat) & wrap_mask;
      end
      else
      begin
         low_bits = (start_col[2:0] + beat) & wrap_mask;
      end
      cur_col = (start_col & ~{7'h00, wrap_mask}) | {7'h00, low_bits};
   end

   // ------------------------------------------------------------
   // Banks and open rows
   // ------------------------------------------------------------
   logic [ROW_W-1:0] row_of [NUM_BANKS];
   genvar b;
   generate
      for (b = 0; b < NUM_BANKS; b++)
      begin : bank
         always_ff @(posedge clk or posedge rst)  // see [RL2]
         begin
            if (rst)
            begin
               bank_open[b] <= 1'b0;
               row_of[b] <= ROW_RESET;
            end
            else if (is_act && bank_q == b)  // see [RL7]
            begin
               bank_open[b] <= 1'b1;
               row_of[b] <= row_in;
            end
            else if (is_pre && (addr_q[PRE_BIT] || bank_q == b))  // see [RL15]
            begin
               bank_open[b] <= 1'b0;
            end
            else if (bst_end && auto_pre && bst_bank == b)  // see [RL11]
            begin
               bank_open[b] <= 1'b0;
            end
         end
         assign open_rows[b*ROW_W +: ROW_W] = row_of[b];
      end
   endgenerate

   // ------------------------------------------------------------
   // Storage window (low address bits only)
   // ------------------------------------------------------------
   logic [MEM_AW-1:0] mem_addr;
   logic [DATA_W-1:0] mem_rd;
   logic mem_we;
   logic [LANES-1:0] mem_lane;
   logic [LANES-1:0] mask_d1;
   logic [DATA_W-1:0] din_d1;
   logic [DATA_W-1:0] mem_rd_d1;
   assign mem_addr = {bst_bank, row_of[bst_bank][1:0], cur_col[4:0]};
   assign mem_we = (state == ST_WRITE);
   // Write beats run one cycle behind their sampled data and mask
   assign mem_lane = ~mask_d1;  // see [RL17]

   sbb_mem u_mem
   (
      .clk(clk),
      .wr_en(mem_we),
      .wr_lane(mem_lane),
      .addr(mem_addr),
      .wr_data(din_d1),
      .rd_data(mem_rd)
   );

   // ------------------------------------------------------------
   // Read pipeline with CAS latency and mask latency
   // ------------------------------------------------------------
   logic [CL_MAX-1:0] rd_vld;
   logic [LANES-1:0] mask_d2;
   logic rd_now;
   assign rd_now = (state == ST_READ);

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         rd_vld <= '0;
         mask_d1 <= '0;
         mask_d2 <= '0;
         din_d1 <= '0;
         mem_rd_d1 <= '0;
      end
      else
      begin
         rd_vld <= {rd_vld[CL_MAX-2:0], rd_now};
         mask_d1 <= mask_q;
         mask_d2 <= mask_d1;
         din_d1 <= din_q;
         mem_rd_d1 <= mem_rd;
      end
   end

   logic word_due;
   assign word_due = (cas_latency == 2'h3) ? rd_vld[1] : rd_vld[0];

   always_ff @(posedge clk or posedge rst)  // see [RL18]
   begin
      if (rst)
      begin
         dq_out <= '0;
         dq_oe_n <= '1;
      end
      else
      begin
         dq_out <= (cas_latency == 2'h3) ? mem_rd_d1 : mem_rd;  // see [RL18]
         dq_oe_n <= word_due ? mask_d1 : '1;  // see [RL17]
      end
   end
endmodule

//--- sim/sbb_core_assertions.sv
`timescale 1ns/1ps
module sbb_core_assertions
(
   input wire logic clk,
   input wire logic rst,
   input wire logic chip_select_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic bank_select_low,
   input wire logic bank_select_high,
   input wire logic [sbb_pkg::ADDR_W-1:0] row_column_address_lines,
   input wire logic lower_byte_lane_mask,
   input wire logic upper_byte_lane_mask,
   input wire logic [sbb_pkg::LANES-1:0] dq_oe_n,
   input wire logic [sbb_pkg::NUM_BANKS-1:0] bank_open,
   input wire logic [sbb_pkg::NUM_BANKS*sbb_pkg::ROW_W-1:0] open_rows
);
   import sbb_pkg::*;
   logic [2:0] cmd;
   logic go;
   logic b0;
   logic ap;
   logic [3:0] quiet;
   logic [ROW_W-1:0] row0;
   assign cmd = {ras_n, cas_n, we_n};
   assign go = !chip_select_n;
   assign b0 = !bank_select_low && !bank_select_high;
   assign ap = row_column_address_lines[PRE_BIT];
   // Cycles since the last accepted read, saturating
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         quiet <= 4'hf;
      else if (go && cmd == CMD_READ)
         quiet <= 4'h0;
      else if (quiet != 4'hf)
         quiet <= quiet + 4'h1;
   end
   always_ff @(posedge clk)
   begin
      if (go && cmd == CMD_ACTIVATE && b0)
         row0 <= row_column_address_lines;
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   a_act_opens_row: assert property (go && cmd == CMD_ACTIVATE && b0 |->
      ##[1:3] bank_open[0] && open_rows[ROW_W-1:0] == row0) else $error("row not opened");
   a_cs_blocks: assert property (chip_select_n |=>
      (bank_open & ~$past(bank_open)) == 4'h0) else $error("deselected command acted");
   a_idle_quiet: assert property (quiet >= 4'he |-> dq_oe_n == 2'h3)
      else $error("output driven without read");
   a_data_late: assert property ($fell(dq_oe_n[0]) |-> quiet <= 4'h6)
      else $error("read data too late");
   a_lower_float: assert property (lower_byte_lane_mask [*4] |=> dq_oe_n[0])
      else $error("lower byte driven under mask");
   a_upper_float: assert property (upper_byte_lane_mask [*4] |=> dq_oe_n[1])
      else $error("upper byte driven under mask");
   a_ap_closes: assert property (go && cmd == CMD_READ && ap && b0 |->
      ##[1:16] !bank_open[0]) else $error("auto precharge missing");
   a_pre_all: assert property (go && cmd == CMD_PRECHARGE && ap |->
      ##[1:3] bank_open == 4'h0) else $error("all bank precharge failed");
   a_pre_one: assert property (go && cmd == CMD_PRECHARGE && !ap && b0 |->
      ##[1:3] !bank_open[0]) else $error("bank precharge failed");
   c_read: cover property (go && cmd == CMD_READ);
   c_data: cover property ($fell(dq_oe_n[0]));
   c_pre: cover property (go && cmd == CMD_PRECHARGE);
endmodule
bind sbb_core sbb_core_assertions i_sbb_core_assertions (.*);

//--- sim/sbb_ctl_model.sv
`timescale 1ns/1ps
module sbb_ctl_model
(
   input wire logic clk,
   output logic chip_select_n,
   output logic ras_n,
   output logic cas_n,
   output logic we_n,
   output logic bank_select_low,
   output logic bank_select_high,
   output logic [sbb_pkg::ADDR_W-1:0] row_column_address_lines,
   output logic lower_byte_lane_mask,
   output logic upper_byte_lane_mask,
   output logic [sbb_pkg::DATA_W-1:0] dq_in
);
   import sbb_pkg::*;
   initial
   begin
      {chip_select_n, ras_n, cas_n, we_n} = 4'hf;
      {bank_select_high, bank_select_low} = 2'h0;
      row_column_address_lines = '0;
      {upper_byte_lane_mask, lower_byte_lane_mask} = 2'h0;
      dq_in = '0;
   end
   // One command a cycle, driven after an edge and held to the next
   task automatic issue(input logic cs_n, input sbb_cmd_t c, input logic [1:0] b,
      input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic [1:0] m);
      @(posedge clk);
      #2;
      chip_select_n = cs_n;
      {ras_n, cas_n, we_n} = c;
      {bank_select_high, bank_select_low} = b;
      row_column_address_lines = a;
      {upper_byte_lane_mask, lower_byte_lane_mask} = m;
      dq_in = (c == CMD_WRITE) ? d : ~dq_in;
   endtask
endmodule

//--- sim/tb.sv
`timescale 1ns/1ps
module tb;
   import sbb_pkg::*;
   logic clk, rst, interleave, chip_select_n, ras_n, cas_n, we_n;
   logic bank_select_low, bank_select_high, lower_byte_lane_mask, upper_byte_lane_mask;
   logic [1:0] org_select, burst_length, cas_latency, dq_oe_n;
   logic [ADDR_W-1:0] row_column_address_lines;
   logic [DATA_W-1:0] dq_in, dq_out;
   logic [NUM_BANKS-1:0] bank_open;
   logic [NUM_BANKS*ROW_W-1:0] open_rows;
   logic [DATA_W-1:0] q[$];
   int n_mismatch = 0;
   int n_tests = 0;
   int fst;
   sbb_core i_sbb_core (.*);
   sbb_ctl_model i_sbb_ctl_model (.*);
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic chk_w(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[ERR] %0t word %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_b(input logic [NUM_BANKS-1:0] got, input logic [NUM_BANKS-1:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[ERR] %0t banks %b expected %b", $time, got, exp);
      end
   endtask
   task automatic cmd(input sbb_cmd_t c, input logic [1:0] b, input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] d);
      i_sbb_ctl_model.issue(1'b0, c, b, a, d, 2'h0);
   endtask
   // Idle cycles, collecting every fully driven read word
   task automatic idle(input int n, input logic [1:0] m);
      for (int k = 1; k <= n; k++)
      begin
         i_sbb_ctl_model.issue(1'b0, CMD_NOP, 2'h0, '0, '0, m);
         if (dq_oe_n === 2'h0)
         begin
            if (q.size() == 0)
               fst = k;
            q.push_back(dq_out);
         end
      end
   endtask
   function automatic logic [DATA_W-1:0] pat(input int c);
      return (c == 3) ? 16'h9903 : 16'h3c00 | 16'(c);
   endfunction
   task automatic rd(input logic [COL_W-1:0] s, input int n, input logic il);
      logic [COL_W-1:0] c;
      q = {};
      cmd(CMD_READ, 2'h0, 14'(s), '0);
      idle(14, 2'h0);
      chk_w(16'(q.size()), 16'(n));
      for (int k = 0; k < n && k < q.size(); k++)
      begin
         c = COL_W'(il ? s ^ k : (s & ~(n - 1)) | ((s + k) & (n - 1)));
         chk_w(q[k], pat(c));
      end
   endtask
   task automatic t_act();
      repeat (5) i_sbb_ctl_model.issue(1'b1, CMD_ACTIVATE, 2'h0, 14'h0001, '0, 2'h3);
      idle(3, 2'h0);
      chk_b(bank_open, 4'h0);
      for (int b = 0; b < 4; b++)
         cmd(CMD_ACTIVATE, 2'(b), 14'(b + 1), '0);
      idle(3, 2'h0);
      chk_b(bank_open, 4'hf);
      for (int b = 0; b < 4; b++)
         chk_w(16'(open_rows[b*ROW_W +: ROW_W]), 16'(b + 1));
      org_select = ORG_X32_RED;
      cmd(CMD_ACTIVATE, 2'h3, 14'h2005, '0);
      idle(2, 2'h0);
      chk_w(16'(open_rows[3*ROW_W +: ROW_W]), 16'h2005);
      org_select = ORG_X32_STD;
      cmd(CMD_ACTIVATE, 2'h3, 14'h2006, '0);
      idle(2, 2'h0);
      chk_w(16'(open_rows[3*ROW_W +: ROW_W]), 16'h0006);
      org_select = ORG_X16;
      cmd(CMD_ACTIVATE, 2'h3, 14'h2004, '0);
      idle(2, 2'h0);
      chk_w(16'(open_rows[3*ROW_W +: ROW_W]), 16'h0004);
      $display("t_act done");
   endtask
   task automatic t_data();
      int l2;
      for (int c = 0; c < 8; c++)
         cmd(CMD_WRITE, 2'h0, 14'(c), 16'h3c00 | 16'(c));
      i_sbb_ctl_model.issue(1'b0, CMD_WRITE, 2'h0, 14'h0003, 16'h99aa, 2'h1);
      idle(2, 2'h0);
      rd(10'h6, 1, 1'b0);
      burst_length = BL_4;
      rd(10'h5, 4, 1'b0);
      l2 = fst;
      cas_latency = 2'h3;
      rd(10'h5, 4, 1'b0);
      chk_w(16'(fst), 16'(l2 + 1));
      cas_latency = 2'h2;
      burst_length = BL_8;
      interleave = 1'b1;
      rd(10'h3, 8, 1'b1);
      interleave = 1'b0;
      q = {};
      cmd(CMD_READ, 2'h0, 14'h0000, '0);
      cmd(CMD_TERMINATE, 2'h0, 14'h0000, '0);
      idle(14, 2'h0);
      chk_w(16'(q.size() < 8), 16'h1);
      burst_length = BL_2;
      rd(10'h1, 2, 1'b0);
      cmd(CMD_READ, 2'h0, 14'h0001, '0);
      idle(4, 2'h1);
      chk_w(16'(dq_oe_n), 16'h0001);
      chk_w({dq_out[15:8], 8'h00}, 16'h3c00);
      idle(10, 2'h0);
      $display("t_data done");
   endtask
   task automatic t_close();
      cmd(CMD_READ, 2'h0, 14'h0400, '0);
      idle(8, 2'h0);
      chk_b(bank_open, 4'he);
      cmd(CMD_ACTIVATE, 2'h0, 14'h0001, '0);
      idle(2, 2'h0);
      cmd(CMD_PRECHARGE, 2'h0, 14'h0000, '0);
      idle(3, 2'h0);
      chk_b(bank_open, 4'he);
      cmd(CMD_PRECHARGE, 2'h2, 14'h0400, '0);
      idle(3, 2'h0);
      chk_b(bank_open, 4'h0);
      $display("t_close done");
   endtask
   task automatic results();
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial
   begin
      rst = 1'b1;
      org_select = ORG_X16;
      burst_length = BL_1;
      interleave = 1'b0;
      cas_latency = 2'h2;
      repeat (12) @(posedge clk);
      #2;
      rst = 1'b0;
      t_act();
      t_data();
      t_close();
      results();
   end
   initial
   begin
      #(50 * 2000);
      n_mismatch++;
      results();
   end
endmodule
